//--- hdl/fpsc_top.sv
// fan pwm configuration, smoothing ramp and open-drain output stage
`timescale 1ns/100ps
`default_nettype none
// Operation
// - with the format bit clear the setpoints are read as signed values.
// - with the format bit set the setpoints are read as unsigned values.
// - the two-bit ramp rate picks the interval between smoothing steps.
// - the ramp rate field only takes writes while programming is enabled.
// - the smoothing enable bit only takes writes while programming is enabled.
// - smoothing off applies duty changes at once, on ramps at the chosen rate.
// - spin-up and critical override bypass smoothing; only table moves ramp.
// - smoothing only acts at the 22.5 kHz pwm frequency.
// - bits 7:6 of the fan configuration register always read zero.
// - with programming disabled, pwm value and smoothing bits ignore writes.
// - with programming disabled, duty comes from the table and reads back.
// - with programming enabled, a pwm value write sets the output duty.
// - polarity 0 pulls the pin low for fan off and releases it for fan on.
// - polarity 1 releases the pin for fan off and pulls it low for fan on.
// - high resolution at 22.5 kHz gives fine steps instead of 6.25 percent.
module fpsc_top
  import fpsc_pkg::*;
#(
  parameter int RAMP_CYCLES0 = RAMP_CYC0,
  parameter int RAMP_CYCLES1 = RAMP_CYC1,
  parameter int RAMP_CYCLES2 = RAMP_CYC2,
  parameter int RAMP_CYCLES3 = RAMP_CYC3
) (
  // clock and reset
  input wire logic I_SYS_CLK,
  input wire logic I_RESETN,
  // register port
  input wire logic I_REG_WR,
  input wire logic [7:0] I_REG_ADDR,
  input wire logic [7:0] I_REG_WDATA,
  output logic [7:0] O_REG_RDATA,
  // duty sources from the rest of the fan controller
  input wire logic [7:0] I_TABLE_DUTY,
  input wire logic I_SPINUP_ACTIVE,
  input wire logic [7:0] I_SPINUP_DUTY,
  input wire logic I_CRIT_OVERRIDE,
  input wire logic I_FREQ_22K5,
  input wire logic I_PWM_STEP_EN,
  // setpoint interpretation
  input wire logic [10:0] I_SETPOINT_RAW,
  output logic signed [11:0] O_SETPOINT_VALUE,
  output logic O_SETPOINT_UNSIGNED,
  // status and open-drain pwm pin
  output logic [7:0] O_DUTY,
  output logic O_PWM_O,
  output logic O_PWM_OE
);
  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [2:0] enh_misc_reg;
  logic unsigned_reg;
  logic [1:0] rate_reg;
  logic smooth_en_reg;
  logic prog_en_reg;
  logic polarity_reg;
  logic [3:0] fan_misc_reg;
  logic [7:0] pwm_val_reg;
  logic [7:0] duty_reg;
  logic [7:0] duty_next;
  logic [7:0] pwm_cnt_reg;

  wire wr_enh = I_REG_WR && (I_REG_ADDR == ADDR_ENH_CFG);
  wire wr_fan = I_REG_WR && (I_REG_ADDR == ADDR_FAN_CFG);
  wire wr_val = I_REG_WR && (I_REG_ADDR == ADDR_PWM_VAL);
  wire wr_smooth = wr_enh && prog_en_reg;

  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      enh_misc_reg <= 3'h0;
      unsigned_reg <= 1'b0;
      rate_reg <= 2'h0;
      smooth_en_reg <= 1'b0;
      prog_en_reg <= FAN_PROG_EN_RST;
      polarity_reg <= 1'b0;
      fan_misc_reg <= 4'h0;
      pwm_val_reg <= PWM_VAL_RST;
    end else begin
      if (wr_enh) begin
        enh_misc_reg <= I_REG_WDATA[6:4];
        unsigned_reg <= I_REG_WDATA[ENH_UNSIGNED_BIT];
      end
      if (wr_smooth) begin
        rate_reg <= I_REG_WDATA[ENH_RATE_LSB +: 2];
        smooth_en_reg <= I_REG_WDATA[ENH_SMOOTH_BIT];
      end
      if (wr_fan) begin
        prog_en_reg <= I_REG_WDATA[FAN_PROG_EN_BIT];
        polarity_reg <= I_REG_WDATA[FAN_POLARITY_BIT];
        fan_misc_reg <= I_REG_WDATA[3:0];
      end
      if (wr_val && prog_en_reg) begin
        pwm_val_reg <= I_REG_WDATA;
      end
    end
  end

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  wire [7:0] enh_rd = {1'b0, enh_misc_reg, unsigned_reg, rate_reg, smooth_en_reg};
  wire [7:0] fan_rd = {2'b00, prog_en_reg, polarity_reg, fan_misc_reg};
  assign O_REG_RDATA = (I_REG_ADDR == ADDR_ENH_CFG) ? enh_rd :
                       (I_REG_ADDR == ADDR_FAN_CFG) ? fan_rd :
                       (I_REG_ADDR == ADDR_PWM_VAL) ? duty_reg : 8'h00;

  // ---------------------------------------------------------------
  // setpoint format
  // ---------------------------------------------------------------
  assign O_SETPOINT_UNSIGNED = unsigned_reg;
  assign O_SETPOINT_VALUE = unsigned_reg ? $signed({1'b0, I_SETPOINT_RAW}) :
                            $signed({I_SETPOINT_RAW[10], I_SETPOINT_RAW});

  // ---------------------------------------------------------------
  // duty selection and smoothing ramp
  // ---------------------------------------------------------------
  wire fine = enh_misc_reg[ENH_HIGH_RES_BIT - 4] && I_FREQ_22K5;
  wire [7:0] step = fine ? DUTY_STEP_FINE : DUTY_STEP_COARSE;
  wire [7:0] table_duty = fine ? I_TABLE_DUTY : (I_TABLE_DUTY & 8'hf0);
  // override and spin-up win over the table and the programmed value
  wire [7:0] target = I_CRIT_OVERRIDE ? DUTY_FULL :
                      I_SPINUP_ACTIVE ? I_SPINUP_DUTY :
                      prog_en_reg ? pwm_val_reg : table_duty;
  wire ramp_mode = smooth_en_reg && I_FREQ_22K5 && !prog_en_reg &&
                   !I_CRIT_OVERRIDE && !I_SPINUP_ACTIVE;
  wire ramp_busy = ramp_mode && (duty_reg != target);
  wire ramp_tick;
  wire up = target > duty_reg;
  wire [7:0] gap = up ? target - duty_reg : duty_reg - target;

  fpsc_ramp_tick #(
    .CYC0(RAMP_CYCLES0),
    .CYC1(RAMP_CYCLES1),
    .CYC2(RAMP_CYCLES2),
    .CYC3(RAMP_CYCLES3)
  ) u_ramp_tick (
    .i_clk(I_SYS_CLK),
    .i_resetn(I_RESETN),
    .i_run(ramp_busy),
    .i_rate(rate_reg),
    .o_tick(ramp_tick)
  );

  always_comb begin
    duty_next = duty_reg;
    if (!ramp_mode) begin
      duty_next = target;
    end else if (ramp_tick) begin
      if (gap <= step) begin
        duty_next = target;
      end else if (up) begin
        duty_next = duty_reg + step;
      end else begin
        duty_next = duty_reg - step;
      end
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      duty_reg <= PWM_VAL_RST;
      pwm_cnt_reg <= 8'h00;
    end else begin
      duty_reg <= duty_next;
      if (I_PWM_STEP_EN) begin
        pwm_cnt_reg <= pwm_cnt_reg + 8'h01;
      end
    end
  end

  // ---------------------------------------------------------------
  // open-drain output stage
  // ---------------------------------------------------------------
  wire fan_on = (pwm_cnt_reg < duty_reg) || (duty_reg == DUTY_FULL);
  assign O_DUTY = duty_reg;
  assign O_PWM_O = 1'b0;
  // the pin only ever pulls low; the fan pull-up makes the open level
  assign O_PWM_OE = polarity_reg ? fan_on : !fan_on;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RESETN);

  chk_rate_locked: assert property (
    (wr_enh && !prog_en_reg) |=> $stable(rate_reg)) else $error("rate changed while locked");
  chk_smooth_locked: assert property (
    (wr_enh && !prog_en_reg) |=> $stable(smooth_en_reg)) else $error("smooth en changed");
  chk_val_locked: assert property (
    (wr_val && !prog_en_reg) |=> $stable(pwm_val_reg)) else $error("pwm value changed");
  chk_direct_write: assert property (
    (wr_val && prog_en_reg && !I_CRIT_OVERRIDE && !I_SPINUP_ACTIVE)
      ##1 (!I_CRIT_OVERRIDE && !I_SPINUP_ACTIVE && prog_en_reg)
      |=> (O_DUTY == $past(I_REG_WDATA, 2))) else $error("written duty not applied");
  chk_fan_rsvd: assert property (
    (I_REG_ADDR == ADDR_FAN_CFG) |-> (O_REG_RDATA[7:6] == 2'b00)) else $error("reserved set");
  chk_no_ramp_crit: assert property (
    I_CRIT_OVERRIDE ##1 I_CRIT_OVERRIDE |-> (O_DUTY == DUTY_FULL)) else $error("override ramped");
  chk_ramp_step: assert property (
    (ramp_mode && $past(ramp_mode) && $changed(duty_reg))
      |-> ((duty_reg - $past(duty_reg) == $past(step)) ||
           ($past(duty_reg) - duty_reg == $past(step)) ||
           (duty_reg == $past(target)))) else $error("ramp step size wrong");
  chk_no_smooth_slow: assert property (
    !I_FREQ_22K5 |=> (O_DUTY == $past(target)))
    else $error("smoothing acted off 22.5 kHz");
  chk_polarity: assert property (
    (!polarity_reg && duty_reg == 8'h00) |-> O_PWM_OE) else $error("fan off not pulled low");
  chk_signed_fmt: assert property (
    !unsigned_reg |-> (O_SETPOINT_VALUE[11] == I_SETPOINT_RAW[10])) else $error("sign lost");

  cov_ramp_step: cover property (ramp_mode && ramp_tick && (gap > step));
  cov_locked_write: cover property (wr_enh && !prog_en_reg);
  cov_coarse_step: cover property (ramp_mode && ramp_tick && !fine && (gap > step));
  cov_crit_override: cover property (I_CRIT_OVERRIDE && smooth_en_reg && I_FREQ_22K5);
endmodule // fpsc_top
`default_nettype wire

//--- hdl/fpsc_pkg.sv
// constants shared by the fan pwm smoothing/config block
`default_nettype none
package fpsc_pkg;
  // register offsets
  localparam logic [7:0] ADDR_ENH_CFG = 8'h45;
  localparam logic [7:0] ADDR_FAN_CFG = 8'h4a;
  localparam logic [7:0] ADDR_PWM_VAL = 8'h4c;
  // enhanced configuration field positions
  localparam int ENH_HIGH_RES_BIT = 4;
  localparam int ENH_UNSIGNED_BIT = 3;
  localparam int ENH_RATE_LSB = 1;
  localparam int ENH_SMOOTH_BIT = 0;
  // fan pwm / tach configuration field positions
  localparam int FAN_PROG_EN_BIT = 5;
  localparam int FAN_POLARITY_BIT = 4;
  // reset values
  localparam logic FAN_PROG_EN_RST = 1'b1;
  localparam logic [7:0] PWM_VAL_RST = 8'h00;
  // duty scale: high resolution is one count, low resolution sixteen
  localparam logic [7:0] DUTY_STEP_FINE = 8'h01;
  localparam logic [7:0] DUTY_STEP_COARSE = 8'h10;
  localparam logic [7:0] DUTY_FULL = 8'hff;
  // ramp intervals in microseconds; code 10 taken as 91 ms
  localparam int CLK_MHZ = 100;
  localparam int RAMP_T0_US = 23000;
  localparam int RAMP_T1_US = 46000;
  localparam int RAMP_T2_US = 91000;
  localparam int RAMP_T3_US = 182000;
  localparam int RAMP_CYC0 = RAMP_T0_US * CLK_MHZ;
  localparam int RAMP_CYC1 = RAMP_T1_US * CLK_MHZ;
  localparam int RAMP_CYC2 = RAMP_T2_US * CLK_MHZ;
  localparam int RAMP_CYC3 = RAMP_T3_US * CLK_MHZ;
  localparam int RAMP_CNT_W = 25;
endpackage
`default_nettype wire

//--- hdl/fpsc_ramp_tick.sv
// ramp interval divider: one-cycle tick per selected smoothing interval
`timescale 1ns/100ps
`default_nettype none
module fpsc_ramp_tick
  import fpsc_pkg::*;
#(
  parameter int CYC0 = RAMP_CYC0,
  parameter int CYC1 = RAMP_CYC1,
  parameter int CYC2 = RAMP_CYC2,
  parameter int CYC3 = RAMP_CYC3
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_run,
  input wire logic [1:0] i_rate,
  output logic o_tick
);
  logic [RAMP_CNT_W-1:0] cnt_reg;
  logic [RAMP_CNT_W-1:0] cnt_next;
  wire [RAMP_CNT_W-1:0] limit = (i_rate == 2'h0) ? RAMP_CNT_W'(CYC0 - 1) :
                                (i_rate == 2'h1) ? RAMP_CNT_W'(CYC1 - 1) :
                                (i_rate == 2'h2) ? RAMP_CNT_W'(CYC2 - 1) :
                                RAMP_CNT_W'(CYC3 - 1);
  wire at_limit = (cnt_reg >= limit);
  // idle resets the count so a new ramp waits a full interval first
  assign cnt_next = (!i_run || at_limit) ? '0 : cnt_reg + RAMP_CNT_W'(1);
  assign o_tick = i_run && at_limit;
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
endmodule // fpsc_ramp_tick
`default_nettype wire

//--- test/fpsc_fan_model.sv
// fan model: sees the open-drain pwm pin through a pull-up and counts released cycles
`timescale 1ns/100ps
`default_nettype none
module fpsc_fan_model (
  // clock
  input wire logic i_clk,
  // pin drive and measurement window
  input wire logic i_pin_o,
  input wire logic i_pin_oe,
  input wire logic i_count_en,
  output logic o_pin,
  output var int o_high_cnt
);
  // pull-up holds the line high whenever nobody sinks it
  assign o_pin = i_pin_oe ? i_pin_o : 1'b1;
  always @(posedge i_clk) begin
    if (!i_count_en) begin
      o_high_cnt <= 0;
    end else if (o_pin === 1'b1) begin
      o_high_cnt <= o_high_cnt + 1;
    end
  end
endmodule // fpsc_fan_model
`default_nettype wire

//--- test/fpsc_top_tb.sv
// self-checking bench for the fan pwm configuration and smoothing block
`timescale 1ns/100ps
`default_nettype none
module fpsc_top_tb;
  import fpsc_pkg::*;
  // short ramp intervals keep the run brief
  localparam int NCYC[4] = '{4, 6, 8, 10};
  logic clk = 0, rstn = 0, wr = 0, spin = 0, crit = 0, f22 = 1, cnt_en = 0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, tab = 8'h00, spind = 8'h00;
  logic [10:0] raw = 11'h000;
  logic [7:0] rdata, duty;
  logic signed [11:0] spv;
  logic spu, po, poe, pin;
  int err_count = 0, comparisons = 0, hi, d, s, w;
  int exp_q[$];
  always #5 clk = ~clk;
  fpsc_top #(.RAMP_CYCLES0(NCYC[0]), .RAMP_CYCLES1(NCYC[1]), .RAMP_CYCLES2(NCYC[2]),
    .RAMP_CYCLES3(NCYC[3])) dut (.I_SYS_CLK(clk), .I_RESETN(rstn), .I_REG_WR(wr),
    .I_REG_ADDR(addr), .I_REG_WDATA(wdata), .O_REG_RDATA(rdata), .I_TABLE_DUTY(tab),
    .I_SPINUP_ACTIVE(spin), .I_SPINUP_DUTY(spind), .I_CRIT_OVERRIDE(crit),
    .I_FREQ_22K5(f22), .I_PWM_STEP_EN(1'b1), .I_SETPOINT_RAW(raw),
    .O_SETPOINT_VALUE(spv), .O_SETPOINT_UNSIGNED(spu), .O_DUTY(duty), .O_PWM_O(po),
    .O_PWM_OE(poe));
  fpsc_fan_model fan (.i_clk(clk), .i_pin_o(po), .i_pin_oe(poe), .i_count_en(cnt_en),
    .o_pin(pin), .o_high_cnt(hi));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic wrr(input logic [7:0] a, input logic [7:0] v);
    cyc(1);
    wr = 1;
    addr = a;
    wdata = v;
    cyc(1);
    wr = 0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] v);
    cyc(1);
    addr = a;
    #1 chk({4'h0, rdata}, {4'h0, v});
  endtask
  // one full 256-step pwm period, so any start phase gives the exact count
  task automatic pwm(input int exp);
    cyc(1);
    cnt_en = 1;
    cyc(256);
    chk(hi[11:0], exp[11:0]);
    cnt_en = 0;
  endtask
  task automatic step_wait(input int lim, output int gap);
    logic [7:0] old;
    old = duty;
    gap = 0;
    while (duty === old && gap <= lim) begin
      cyc(1);
      gap++;
    end
  endtask
  // reference ramp: one resolution step per interval, last step lands on the target
  task automatic plan_ramp(input int from, input int to, input int stp);
    int v;
    v = from;
    while (v != to) begin
      v = (to - v > stp) ? v + stp : (v - to > stp) ? v - stp : to;
      exp_q.push_back(v);
    end
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    void'($urandom(32'h5ff14371));
    cyc(16);
    rstn = 1;
    rdc(ADDR_ENH_CFG, 8'h00);
    rdc(ADDR_FAN_CFG, 8'h20);
    rdc(ADDR_PWM_VAL, 8'h00);
    rdc(8'h46, 8'h00);
    $display("test reset done");
    for (int f = 0; f < 2; f++) begin
      wrr(ADDR_ENH_CFG, 8'(f << 3));
      raw = 11'($urandom);
      cyc(1);
      chk(spv, f ? {1'b0, raw} : {raw[10], raw});
      chk({11'h0, spu}, 12'(f));
    end
    $display("test setpoint format done");
    wrr(ADDR_FAN_CFG, 8'hff);
    rdc(ADDR_FAN_CFG, 8'h3f);
    wrr(ADDR_ENH_CFG, 8'h10);
    d = 1 + $urandom % 254;
    wrr(ADDR_PWM_VAL, 8'(d));
    cyc(2);
    chk({4'h0, duty}, 12'(d));
    pwm(256 - d);
    wrr(ADDR_FAN_CFG, 8'h20);
    pwm(d);
    $display("test polarity done");
    for (int c = 0; c < 4; c++) begin
      s = $urandom % 200;
      wrr(ADDR_PWM_VAL, 8'(s));
      wrr(ADDR_ENH_CFG, 8'(8'h11 | (c << 1)));
      tab = 8'(s);
      wrr(ADDR_FAN_CFG, 8'h00);
      cyc(2);
      chk({4'h0, duty}, 12'(s));
      tab = 8'(s + 3);
      plan_ramp(s, s + 3, 1);
      for (int k = 1; k <= 3; k++) begin
        step_wait(NCYC[c] + 2, w);
        chk({4'h0, duty}, 12'(exp_q.pop_front()));
        if (k > 1) chk(12'(w >= NCYC[c] && w <= NCYC[c] + 1), 12'h001);
      end
      cyc(2 * NCYC[c]);
      chk({4'h0, duty}, 12'(s + 3));
      wrr(ADDR_FAN_CFG, 8'h20);
    end
    $display("test smoothing ramp done");
    tab = 8'(s);
    wrr(ADDR_FAN_CFG, 8'h00);
    wrr(ADDR_ENH_CFG, 8'h18);
    rdc(ADDR_ENH_CFG, 8'h1f);
    wrr(ADDR_PWM_VAL, 8'h55);
    rdc(ADDR_PWM_VAL, 8'(s));
    tab = 8'(s + 40);
    cyc(3);
    crit = 1;
    cyc(2);
    chk({4'h0, duty}, 12'h0ff);
    crit = 0;
    spin = 1;
    spind = 8'($urandom);
    cyc(2);
    chk({4'h0, duty}, {4'h0, spind});
    spin = 0;
    f22 = 0;
    tab = 8'($urandom);
    cyc(2);
    chk({4'h0, duty}, {4'h0, tab & 8'hf0});
    $display("test override and protection done");
    // low resolution ramp: sixteen-count steps, rate code 3 still locked in
    tab = 8'h20;
    wrr(ADDR_ENH_CFG, 8'h00);
    f22 = 1;
    tab = 8'h47;
    plan_ramp(8'h20, 8'h40, 8'h10);
    for (int k = 0; k < 2; k++) begin
      step_wait(NCYC[3] + 2, w);
      chk({4'h0, duty}, 12'(exp_q.pop_front()));
      chk(12'(w >= NCYC[3] && w <= NCYC[3] + 1), 12'h001);
    end
    $display("test coarse ramp done");
    end_of_test();
  end
  // the tests need well under 5000 cycles
  initial begin
    #200000;
    err_count++;
    end_of_test();
  end
endmodule // fpsc_top_tb
`default_nettype wire
